// >>> src/isa_ctl_map.svh
`ifndef ISA_CTL_MAP_SVH
`define ISA_CTL_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_MGMT 8'h04
`define ADDR_MASK 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_RTC_CMD 8'h10
`define ADDR_RTC_DATA 8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_CLK_SEL 0
`define CTRL_DIV_LSB 4
`define CTRL_SMM 8
`define CTRL_MEM2MEM 9
`define CTRL_AUTO_LSB 16
`define CTRL_LWAIT_LSB 24
`define CTRL_RESET 32'h0200_0020

// ----------------------------------------
// Clock-chip command and data register fields
// ----------------------------------------
`define RTC_ADDR_LSB 0
`define RTC_DATA_LSB 8
`define RTC_WRITE 16
`define RTC_BUSY 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define HCLK_MHZ 40
`define RTC_STROBE_NS 150
`define RTC_STROBE_CYC ((`RTC_STROBE_NS * `HCLK_MHZ + 999) / 1000)
`define ISA_CMD_MIN_CYC 4
`define IORDY_SYNC_CYC 4

`endif

// >>> src/isa_ctl_pkg.sv
package isa_ctl_pkg;
   typedef enum logic [2:0] {
      CYC_IDLE, CYC_SETUP, CYC_CMD, CYC_WAIT, CYC_DONE
   } cyc_state_t;

   typedef enum logic [2:0] {
      RTC_IDLE, RTC_ADDR, RTC_GAP, RTC_DATA, RTC_END
   } rtc_state_t;
endpackage

// >>> src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
         level <= INIT;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // A change counts only once the last two stages agree
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               level[i] <= s3_ff[i];
            end
         end
      end
   end
endmodule

// >>> src/isa_side_ctl.sv
`timescale 1ns/1ps
`include "isa_ctl_map.svh"
module isa_side_ctl
   import isa_ctl_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // ISA cycle requests from core logic
   input wire logic cyc_start,
   input wire logic cyc_write,
   input wire logic cyc_high_byte,
   input wire logic cyc_periph,
   input wire logic cyc_cross,
   output logic cyc_done,
   // DMA and local-target status from core logic
   input wire logic dma_active,
   input wire logic local_target_access,
   input wire logic [CHANNELS-1:0] dma_tc_reached,
   input wire logic [1:0] dma_active_chan,
   output logic [CHANNELS-1:0] dma_service_end,
   output logic [CHANNELS-1:0] dma_reload,
   // ISA pins
   input wire logic iordy_in,
   output logic iordy_out,
   output logic iordy_oe,
   input wire logic zero_wait_request_n,
   input wire logic master_req_n,
   output logic isa_ctrl_oe,
   output logic aen,
   output logic tc_out,
   output logic isa_bus_clock,
   input wire logic osc_14m,
   // Buffer controls
   output logic high_byte_buffer_enable_n,
   output logic peripheral_buffer_enable_n,
   output logic local_buffer_direction,
   output logic low_byte_cross_direction,
   // Clock chip and peripheral bus
   output logic clock_chip_address_strobe,
   output logic clock_chip_read_strobe_n,
   output logic clock_chip_write_strobe_n,
   input wire logic [7:0] peripheral_data_bus_in,
   output logic [7:0] peripheral_data_bus_out,
   output logic peripheral_data_bus_oe
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic iordy_s, zws_n_s, master_n_s, osc_s;

   pin_sync #(.WIDTH(4), .INIT(4'hE)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .pin({iordy_in, zero_wait_request_n, master_req_n, osc_14m}),
      .level({iordy_s, zws_n_s, master_n_s, osc_s})
   );

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic [31:0] ctrl_ff;
   logic [7:0] mgmt_output_port_ff;
   logic [CHANNELS-1:0] mask_ff;
   logic [CHANNELS-1:0] tc_status_ff;
   logic [16:0] rtc_cmd_ff;
   logic [7:0] rtc_rdata_ff;
   logic rtc_go_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] nxt_rdata;
   logic addr_phase;
   logic wr_ctrl, wr_mgmt, wr_mask, wr_status, wr_rtc;
   rtc_state_t rtc_st_ff;

   assign addr_phase = hsel && hready && htrans[1];
   assign wr_ctrl = wr_pend_ff && (wr_addr_ff == `ADDR_CTRL);
   assign wr_mgmt = wr_pend_ff && (wr_addr_ff == `ADDR_MGMT);
   assign wr_mask = wr_pend_ff && (wr_addr_ff == `ADDR_MASK);
   assign wr_status = wr_pend_ff && (wr_addr_ff == `ADDR_STATUS);
   assign wr_rtc = wr_pend_ff && (wr_addr_ff == `ADDR_RTC_CMD);

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (haddr)
         `ADDR_CTRL: nxt_rdata = ctrl_ff;
         `ADDR_MGMT: nxt_rdata = {24'h00_0000, mgmt_output_port_ff};
         `ADDR_MASK: nxt_rdata[CHANNELS-1:0] = mask_ff;
         `ADDR_STATUS: nxt_rdata[CHANNELS-1:0] = tc_status_ff;
         `ADDR_RTC_CMD: nxt_rdata = {15'h0000, rtc_cmd_ff};
         `ADDR_RTC_DATA: nxt_rdata = {23'h00_0000,
            rtc_st_ff != RTC_IDLE, rtc_rdata_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: read data is staged during the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_ff <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_ff <= haddr;
            if (!hwrite) begin
               hrdata <= nxt_rdata;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `CTRL_RESET;
         mgmt_output_port_ff <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= hwdata;
         end
         if (wr_mgmt) begin
            mgmt_output_port_ff <= hwdata[7:0];
         end
      end
   end

   logic clk_sel, smm_mode, mem2mem;
   logic [3:0] clk_div;
   logic [CHANNELS-1:0] auto_init;
   logic [3:0] local_waits;

   assign clk_sel = ctrl_ff[`CTRL_CLK_SEL];
   assign clk_div = ctrl_ff[`CTRL_DIV_LSB +: 4];
   assign smm_mode = ctrl_ff[`CTRL_SMM];
   assign mem2mem = ctrl_ff[`CTRL_MEM2MEM];
   assign auto_init = ctrl_ff[`CTRL_AUTO_LSB +: CHANNELS];
   assign local_waits = ctrl_ff[`CTRL_LWAIT_LSB +: 4];

   // ----------------------------------------
   // Terminal count and channel side effects
   // ----------------------------------------
   logic [CHANNELS-1:0] tc_hit;
   logic [CHANNELS-1:0] act_onehot;

   always_comb begin
      tc_hit = dma_tc_reached;
      act_onehot = '0;
      act_onehot[dma_active_chan] = 1'b1;
      if (mem2mem) begin
         tc_hit[0] = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tc_out <= 1'b0;
         dma_service_end <= '0;
         dma_reload <= '0;
      end else begin
         tc_out <= |tc_hit;
         dma_service_end <= tc_hit;
         dma_reload <= tc_hit & auto_init;
      end
   end

   // Hardware set wins over a software write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_ff <= {CHANNELS{1'b1}};
         tc_status_ff <= '0;
      end else begin
         if (wr_mask) begin
            mask_ff <= hwdata[CHANNELS-1:0];
         end
         if (|tc_hit) begin
            mask_ff <= (wr_mask ? hwdata[CHANNELS-1:0] : mask_ff)
               | (act_onehot & ~auto_init);
         end
         tc_status_ff <= (tc_status_ff
            & ~(wr_status ? hwdata[CHANNELS-1:0] : '0))
            | ((|tc_hit) ? act_onehot : '0);
      end
   end

   // ----------------------------------------
   // Bus ownership and address enable
   // ----------------------------------------
   logic master_on;
   assign master_on = !master_n_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         isa_ctrl_oe <= 1'b0;
         aen <= 1'b0;
      end else begin
         isa_ctrl_oe <= !master_on;
         aen <= dma_active || master_on;
      end
   end

   // ----------------------------------------
   // Wait line driven for local-target accesses
   // ----------------------------------------
   logic [3:0] lwait_cnt_ff;
   logic lt_seen_ff;

   // Drive low for the programmed count, then high once before release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lwait_cnt_ff <= 4'h0;
         lt_seen_ff <= 1'b0;
         iordy_out <= 1'b1;
         iordy_oe <= 1'b0;
      end else begin
         lt_seen_ff <= local_target_access && (dma_active || master_on);
         if (local_target_access && (dma_active || master_on)
             && !lt_seen_ff && local_waits != 4'h0) begin
            lwait_cnt_ff <= local_waits;
            iordy_out <= 1'b0;
            iordy_oe <= 1'b1;
         end else if (lwait_cnt_ff > 4'h1) begin
            lwait_cnt_ff <= lwait_cnt_ff - 4'h1;
         end else if (lwait_cnt_ff == 4'h1) begin
            lwait_cnt_ff <= 4'h0;
            iordy_out <= 1'b1;
         end else begin
            iordy_oe <= 1'b0;
            iordy_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // ISA cycle sequencing and data buffers
   // ----------------------------------------
   cyc_state_t cyc_st_ff;
   logic [3:0] cmd_cnt_ff;
   logic hi_ff, per_ff, wr_ff, cross_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_st_ff <= CYC_IDLE;
         cmd_cnt_ff <= 4'h0;
         hi_ff <= 1'b0;
         per_ff <= 1'b0;
         wr_ff <= 1'b0;
         cross_ff <= 1'b0;
      end else begin
         unique case (cyc_st_ff)
            CYC_IDLE: begin
               if (cyc_start && !master_on) begin
                  hi_ff <= cyc_high_byte;
                  per_ff <= cyc_periph;
                  wr_ff <= cyc_write;
                  cross_ff <= cyc_cross;
                  cyc_st_ff <= CYC_SETUP;
               end
            end
            CYC_SETUP: begin
               cmd_cnt_ff <= 4'(`ISA_CMD_MIN_CYC + `IORDY_SYNC_CYC);
               cyc_st_ff <= CYC_CMD;
            end
            CYC_CMD: begin
               if (!zws_n_s) begin
                  cyc_st_ff <= CYC_DONE;
               end else if (cmd_cnt_ff > 4'h1) begin
                  cmd_cnt_ff <= cmd_cnt_ff - 4'h1;
               end else begin
                  cyc_st_ff <= CYC_WAIT;
               end
            end
            CYC_WAIT: begin
               if (iordy_s || !zws_n_s) begin
                  cyc_st_ff <= CYC_DONE;
               end
            end
            CYC_DONE: cyc_st_ff <= CYC_IDLE;
         endcase
      end
   end

   logic in_xfer;
   assign in_xfer = (cyc_st_ff == CYC_CMD) || (cyc_st_ff == CYC_WAIT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_done <= 1'b0;
         high_byte_buffer_enable_n <= 1'b1;
         peripheral_buffer_enable_n <= 1'b1;
         local_buffer_direction <= 1'b0;
         low_byte_cross_direction <= 1'b0;
      end else begin
         cyc_done <= (cyc_st_ff == CYC_DONE);
         // Direction is settled in the setup cycle, before enables open
         if (cyc_st_ff == CYC_SETUP) begin
            local_buffer_direction <= wr_ff;
            low_byte_cross_direction <= cross_ff;
         end
         high_byte_buffer_enable_n <= !(in_xfer && hi_ff);
         peripheral_buffer_enable_n <= !(in_xfer && per_ff);
      end
   end

   // ----------------------------------------
   // Clock-chip strobes and peripheral bus
   // ----------------------------------------
   logic [7:0] rtc_cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rtc_cmd_ff <= 17'h0_0000;
         rtc_go_ff <= 1'b0;
      end else begin
         rtc_go_ff <= wr_rtc && (rtc_st_ff == RTC_IDLE);
         if (wr_rtc && (rtc_st_ff == RTC_IDLE)) begin
            rtc_cmd_ff <= hwdata[16:0];
         end
      end
   end

   // Address pulse, a gap, then exactly one data strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rtc_st_ff <= RTC_IDLE;
         rtc_cnt_ff <= 8'h00;
         rtc_rdata_ff <= 8'h00;
      end else begin
         unique case (rtc_st_ff)
            RTC_IDLE: begin
               if (rtc_go_ff && !smm_mode) begin
                  rtc_cnt_ff <= 8'(`RTC_STROBE_CYC);
                  rtc_st_ff <= RTC_ADDR;
               end
            end
            RTC_ADDR, RTC_DATA: begin
               if (rtc_cnt_ff > 8'h01) begin
                  rtc_cnt_ff <= rtc_cnt_ff - 8'h01;
               end else begin
                  rtc_cnt_ff <= 8'(`RTC_STROBE_CYC);
                  rtc_st_ff <= (rtc_st_ff == RTC_ADDR) ? RTC_GAP : RTC_END;
               end
            end
            RTC_GAP: rtc_st_ff <= RTC_DATA;
            RTC_END: begin
               if (!rtc_cmd_ff[`RTC_WRITE]) begin
                  rtc_rdata_ff <= peripheral_data_bus_in;
               end
               rtc_st_ff <= RTC_IDLE;
            end
         endcase
      end
   end

   logic rtc_wr;
   assign rtc_wr = rtc_cmd_ff[`RTC_WRITE];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_chip_address_strobe <= 1'b0;
         clock_chip_read_strobe_n <= 1'b1;
         clock_chip_write_strobe_n <= 1'b1;
         peripheral_data_bus_out <= 8'h00;
         peripheral_data_bus_oe <= 1'b0;
      end else begin
         clock_chip_address_strobe <= (rtc_st_ff == RTC_ADDR);
         clock_chip_read_strobe_n <=
            !((rtc_st_ff == RTC_DATA) && !rtc_wr);
         clock_chip_write_strobe_n <=
            !((rtc_st_ff == RTC_DATA) && rtc_wr);
         if (smm_mode) begin
            peripheral_data_bus_out <= mgmt_output_port_ff;
            peripheral_data_bus_oe <= 1'b1;
         end else if (rtc_st_ff == RTC_ADDR || rtc_st_ff == RTC_GAP) begin
            peripheral_data_bus_out <= rtc_cmd_ff[`RTC_ADDR_LSB +: 8];
            peripheral_data_bus_oe <= 1'b1;
         end else if (rtc_st_ff == RTC_DATA && rtc_wr) begin
            peripheral_data_bus_out <= rtc_cmd_ff[`RTC_DATA_LSB +: 8];
            peripheral_data_bus_oe <= 1'b1;
         end else begin
            peripheral_data_bus_out <= 8'h00;
            peripheral_data_bus_oe <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // ISA bus clock
   // ----------------------------------------
   // Oscillator path follows the filtered level, so its edges jitter
   // by up to one core cycle; the divided path is jitter free.
   logic [3:0] div_cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_ff <= 4'h0;
         isa_bus_clock <= 1'b0;
      end else if (clk_sel) begin
         div_cnt_ff <= 4'h0;
         isa_bus_clock <= osc_s;
      end else if (div_cnt_ff >= clk_div) begin
         div_cnt_ff <= 4'h0;
         isa_bus_clock <= !isa_bus_clock;
      end else begin
         div_cnt_ff <= div_cnt_ff + 4'h1;
      end
   end
endmodule

// >>> dv/isa_side_ctl_asserts.sv
`timescale 1ns/1ps
module isa_side_ctl_asserts #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Watched ports
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cyc_done,
   input wire logic dma_active,
   input wire logic [CHANNELS-1:0] dma_tc_reached,
   input wire logic master_req_n,
   input wire logic isa_ctrl_oe,
   input wire logic aen,
   input wire logic tc_out,
   input wire logic high_byte_buffer_enable_n,
   input wire logic peripheral_buffer_enable_n,
   input wire logic local_buffer_direction,
   input wire logic clock_chip_address_strobe,
   input wire logic clock_chip_read_strobe_n,
   input wire logic clock_chip_write_strobe_n
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence as_pulse;
      clock_chip_address_strobe[*6] ##1 !clock_chip_address_strobe;
   endsequence
   sequence wr_pulse;
      !clock_chip_write_strobe_n[*6] ##1 clock_chip_write_strobe_n;
   endsequence
   hready_ok_a: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or errored");
   aen_on_a: assert property (dma_active[*5] |=> aen)
      else $error("address enable low during dma");
   aen_off_a: assert property ((master_req_n && !dma_active)[*5] |=> !aen)
      else $error("address enable high outside dma and master");
   bus_release_a: assert property (!master_req_n[*5] |=> !isa_ctrl_oe)
      else $error("control lines driven under bus master");
   dir_first_a: assert property ($fell(high_byte_buffer_enable_n) |-> $stable(local_buffer_direction))
      else $error("direction moved as buffer opened");
   buf_idle_a: assert property (cyc_done |-> high_byte_buffer_enable_n && peripheral_buffer_enable_n)
      else $error("buffer left open at cycle end");
   tc_pulse_a: assert property (|dma_tc_reached[CHANNELS-1:1] |=> tc_out)
      else $error("terminal count pulse missing");
   tc_cause_a: assert property (tc_out |-> $past(|dma_tc_reached))
      else $error("terminal count pulse without cause");
   as_width_a: assert property ($rose(clock_chip_address_strobe) |-> as_pulse)
      else $error("clock chip address strobe width wrong");
   as_first_a: assert property ($fell(clock_chip_write_strobe_n) |-> wr_pulse and $past(clock_chip_address_strobe, 2))
      else $error("write strobe width or order wrong");
   rd_first_a: assert property ($fell(clock_chip_read_strobe_n) |-> $past(clock_chip_address_strobe, 2))
      else $error("read strobe before address strobe");
   strobe_excl_a: assert property (clock_chip_read_strobe_n || clock_chip_write_strobe_n)
      else $error("clock chip read and write strobes overlap");
endmodule
bind isa_side_ctl isa_side_ctl_asserts #(.CHANNELS(CHANNELS)) chk (
   .hclk, .hresetn, .hreadyout, .hresp, .cyc_done, .dma_active, .dma_tc_reached,
   .master_req_n, .isa_ctrl_oe, .aen, .tc_out, .high_byte_buffer_enable_n,
   .peripheral_buffer_enable_n, .local_buffer_direction,
   .clock_chip_address_strobe, .clock_chip_read_strobe_n,
   .clock_chip_write_strobe_n);

// >>> dv/isa_far_side.sv
`timescale 1ns/1ps
module isa_far_side (
   // Clock
   input wire logic hclk,
   // Device drive
   input wire logic iordy_out,
   input wire logic iordy_oe,
   input wire logic high_byte_buffer_enable_n,
   input wire logic peripheral_buffer_enable_n,
   input wire logic clock_chip_address_strobe,
   input wire logic clock_chip_read_strobe_n,
   input wire logic clock_chip_write_strobe_n,
   input wire logic [7:0] peripheral_data_bus_out,
   input wire logic peripheral_data_bus_oe,
   // Slow device setting
   input wire logic [7:0] slow_waits,
   // Lines seen by the device
   output logic iordy_in,
   output logic [7:0] peripheral_data_bus_in
);
   // ----------------------------------------
   // Slow ISA device and clock chip
   // ----------------------------------------
   logic open_ff = 1'b0;
   logic [7:0] wait_ff = 8'h00;
   logic [7:0] addr_ff = 8'h00;
   logic [7:0] noise_ff = 8'h00;
   logic [7:0] mem [256];
   wire open_now = !(high_byte_buffer_enable_n && peripheral_buffer_enable_n);
   always @(posedge hclk) begin
      open_ff <= open_now;
      noise_ff <= noise_ff + 8'h3B;
      if (open_now && !open_ff) wait_ff <= slow_waits;
      else if (wait_ff != 8'h00) wait_ff <= wait_ff - 8'h01;
      if (clock_chip_address_strobe) addr_ff <= peripheral_data_bus_in;
      if (!clock_chip_write_strobe_n) mem[addr_ff] <= peripheral_data_bus_in;
   end
   // Pulled-up wire: low if either party pulls it
   assign iordy_in = (wait_ff == 8'h00) && !(iordy_oe && !iordy_out);
   // Undriven bus shows a moving pattern, never the last value
   assign peripheral_data_bus_in = peripheral_data_bus_oe ? peripheral_data_bus_out
      : (!clock_chip_read_strobe_n ? mem[addr_ff] : noise_ff);
endmodule

// >>> dv/isa_side_buffer_and_strobe_control_tb.sv
`timescale 1ns/1ps
`include "isa_ctl_map.svh"
module isa_side_buffer_and_strobe_control_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic cyc_start = 0, cyc_write = 0, cyc_high_byte = 0, cyc_periph = 0;
   logic cyc_cross = 0, cyc_done, dma_active = 0, local_target_access = 0;
   logic [3:0] dma_tc_reached = 4'h0, dma_service_end, dma_reload;
   logic [1:0] dma_active_chan = 2'h0;
   logic iordy_in, iordy_out, iordy_oe, zero_wait_request_n = 1;
   logic master_req_n = 1, isa_ctrl_oe, aen, tc_out, isa_bus_clock;
   logic high_byte_buffer_enable_n, peripheral_buffer_enable_n;
   logic local_buffer_direction, low_byte_cross_direction;
   logic clock_chip_address_strobe, clock_chip_read_strobe_n;
   logic clock_chip_write_strobe_n, peripheral_data_bus_oe;
   logic [7:0] peripheral_data_bus_in, peripheral_data_bus_out;
   logic [7:0] slow_waits = 8'h00;
   logic osc = 0;
   int err_count = 0, checks = 0, n;
   isa_side_ctl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cyc_start,
      .cyc_write, .cyc_high_byte, .cyc_periph, .cyc_cross, .cyc_done,
      .dma_active, .local_target_access, .dma_tc_reached, .dma_active_chan,
      .dma_service_end, .dma_reload, .iordy_in, .iordy_out, .iordy_oe,
      .zero_wait_request_n, .master_req_n, .isa_ctrl_oe, .aen, .tc_out,
      .isa_bus_clock, .osc_14m(osc), .high_byte_buffer_enable_n,
      .peripheral_buffer_enable_n, .local_buffer_direction,
      .low_byte_cross_direction, .clock_chip_address_strobe,
      .clock_chip_read_strobe_n, .clock_chip_write_strobe_n,
      .peripheral_data_bus_in, .peripheral_data_bus_out, .peripheral_data_bus_oe);
   isa_far_side far (.hclk, .iordy_out, .iordy_oe, .high_byte_buffer_enable_n,
      .peripheral_buffer_enable_n, .clock_chip_address_strobe,
      .clock_chip_read_strobe_n, .clock_chip_write_strobe_n,
      .peripheral_data_bus_out, .peripheral_data_bus_oe, .slow_waits,
      .iordy_in, .peripheral_data_bus_in);
   initial forever #12.5 hclk = ~hclk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task print_verdict;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task step(input int c);
      repeat (c) @(posedge hclk);
      #1;
   endtask
   task hang;
      err_count++;
      $display("MISMATCH wait expected end seen timeout");
      print_verdict;
   endtask
   // Master waits on hready in both phases
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      n = 0;
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      for (k = 0; k < 2; k++) begin
         do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 60);
         if (n >= 60) hang;
         hsel <= 0;
         htrans <= 2'h0;
         hwdata <= d;
         n = 0;
      end
      rd = hrdata;
   endtask
   task rtc_wait;
      int k;
      for (k = 0; k < 40; k++) begin
         ahb(0, `ADDR_RTC_DATA, 0);
         if (rd[`RTC_BUSY] === 1'b0) break;
      end
      if (k >= 40) hang;
   endtask
   task tc(input int ch, input logic et, input logic [3:0] er);
      @(posedge hclk);
      dma_active_chan <= ch[1:0];
      dma_tc_reached <= 4'h1 << ch;
      @(posedge hclk);
      dma_tc_reached <= 4'h0;
      #1;
      chk("tc_out", et, tc_out);
      chk("service_end", et ? 4'h1 << ch : 4'h0, dma_service_end);
      chk("reload", er, dma_reload);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_isa(input logic w, input int waits, input logic zws);
      logic seen;
      slow_waits <= waits[7:0];
      zero_wait_request_n <= !zws;
      step(4);
      cyc_start <= 1;
      cyc_write <= w;
      cyc_high_byte <= 1;
      cyc_periph <= 1;
      cyc_cross <= w;
      @(posedge hclk);
      cyc_start <= 0;
      n = 0;
      seen = 0;
      while (cyc_done !== 1'b1 && n < 100) begin
         step(1);
         n++;
         if (!high_byte_buffer_enable_n && !peripheral_buffer_enable_n) seen = 1;
      end
      if (n >= 100) hang;
      chk("buffer enables", 1, seen);
      chk("buffer direction", w, local_buffer_direction);
      chk("cross direction", w, low_byte_cross_direction);
      zero_wait_request_n <= 1;
      slow_waits <= 8'h00;
   endtask
   task t_bus;
      logic seen;
      dma_active <= 1;
      step(6);
      chk("aen dma", 1, aen);
      local_target_access <= 1;
      seen = 0;
      repeat (6) begin
         step(1);
         if (iordy_oe === 1'b1 && iordy_out === 1'b0) seen = 1;
      end
      chk("wait drive", 1, seen);
      local_target_access <= 0;
      dma_active <= 0;
      step(6);
      chk("aen idle", 0, aen);
      master_req_n <= 0;
      step(6);
      chk("aen master", 1, aen);
      chk("control release", 0, isa_ctrl_oe);
      master_req_n <= 1;
      step(6);
      chk("control retake", 1, isa_ctrl_oe);
   endtask
   task t_rtc_smm;
      ahb(1, `ADDR_RTC_CMD, 32'h0001_5A37);
      rtc_wait;
      ahb(1, `ADDR_RTC_CMD, 32'h0000_0037);
      rtc_wait;
      chk("clock chip data", 8'h5A, rd[7:0]);
      ahb(1, `ADDR_CTRL, `CTRL_RESET | 32'h0000_0100);
      ahb(1, `ADDR_MGMT, 32'h0000_00A5);
      step(2);
      chk("mgmt port", 9'h1A5, {peripheral_data_bus_oe, peripheral_data_bus_out});
   endtask
   task t_tc;
      ahb(1, `ADDR_CTRL, `CTRL_RESET);
      ahb(1, `ADDR_MASK, 0);
      tc(2, 1, 4'h0);
      ahb(0, `ADDR_MASK, 0);
      chk("mask set", 4'h4, rd[3:0]);
      ahb(0, `ADDR_STATUS, 0);
      chk("status set", 4'h4, rd[3:0]);
      ahb(1, `ADDR_CTRL, `CTRL_RESET | 32'h0008_0000);
      ahb(1, `ADDR_MASK, 0);
      tc(3, 1, 4'h8);
      ahb(0, `ADDR_MASK, 0);
      chk("mask kept", 4'h0, rd[3:0]);
      ahb(1, `ADDR_CTRL, `CTRL_RESET | 32'h0000_0200);
      tc(0, 0, 4'h0);
      tc(1, 1, 4'h0);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      step(4);
      chk("idle pins", 7'h3C, {aen, high_byte_buffer_enable_n,
         peripheral_buffer_enable_n, clock_chip_read_strobe_n,
         clock_chip_write_strobe_n, clock_chip_address_strobe, tc_out});
      ahb(0, `ADDR_CTRL, 0);
      chk("ctrl reset", `CTRL_RESET, rd);
      ahb(0, 8'h40, 0);
      chk("unmapped read", 0, rd);
      n = 0;
      repeat (30) begin
         rd[0] = isa_bus_clock;
         step(1);
         n += rd[0] ^ isa_bus_clock;
      end
      chk("clock toggles", 10, n);
      ahb(1, `ADDR_CTRL, `CTRL_RESET | 32'h0000_0001);
      step(1);
      rd[1] = isa_bus_clock;
      osc <= 1;
      step(6);
      chk("osc clock", 2'h1, {rd[1], isa_bus_clock});
      t_isa(1, 0, 0);
      t_isa(0, 20, 0);
      chk("waits added", 1, n >= 20);
      t_isa(0, 20, 1);
      chk("waits skipped", 1, n < 15);
      t_bus;
      t_tc;
      t_rtc_smm;
      print_verdict;
   end
endmodule
